/* design/pfm_port_mux.sv */
// Six-pin port with direction, pulls, input gating, wake-up, edge interrupt
// and alternate output functions, configured over AXI4-Lite.
// Assumes pin_in arrives asynchronously; comparator, timer and sleep_mode
// signals come from logic on aclk.
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Every pin can be a digital input or push-pull output with a pull-high or pull-low.
// - Clearing a pin's input-enable bit switches its digital input buffer off.
// - A pin whose input-enable bit is zero can never wake the system.
// - An input change on a wake-enabled pin during sleep raises a wake-up.
// - Pin 5 also offers open-drain output and can act as the active-low reset input.
// - Pin 0 raises an external interrupt request on both rising and falling edges.
// - Pin 0 can drive the comparator result out in place of the port latch.
// - Pins 4 and 3 can each drive the second timer PWM in place of the port latch.
// - Pin 4 can feed the comparator positive input; pins 7, 6, 4, 3 the negative one.
module pfm_port_mux (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Pads
  input  wire logic [7:0]       pin_in,
  output pfm_pkg::pfm_pad_t     pad,
  // Shared functions
  input  wire logic             comparator_result_out,
  input  wire logic             second_timer_pwm_out,
  output logic                  comparator_positive_input,
  output logic [1:0]            comparator_negative_input,
  output logic                  hardware_reset_n,
  // System
  input  wire logic             sleep_mode,
  output logic                  wake_up,
  output logic                  external_interrupt_line,
  output logic                  irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == pfm_pkg::ADDR_DOUT)    || (a == pfm_pkg::ADDR_DIR)     ||
              (a == pfm_pkg::ADDR_PULL_EN) || (a == pfm_pkg::ADDR_PULL_SEL) ||
              (a == pfm_pkg::ADDR_DIN_EN)  || (a == pfm_pkg::ADDR_WAKE_EN) ||
              (a == pfm_pkg::ADDR_FUNC)    || (a == pfm_pkg::ADDR_DIN)     ||
              (a == pfm_pkg::ADDR_STATUS)  || (a == pfm_pkg::ADDR_MASK);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]         dout_q, dout_d;
  logic [7:0]         dir_q, dir_d;
  logic [7:0]         pull_en_q, pull_en_d;
  logic [7:0]         pull_sel_q, pull_sel_d;
  logic [7:0]         die_q, die_d;
  logic [7:0]         wake_en_q, wake_en_d;
  pfm_pkg::pfm_func_t func_q, func_d;
  logic [1:0]         status_q, status_d;
  logic [1:0]         mask_q, mask_d;

  logic [7:0]         sync1_q, sync2_q, din_prev_q;
  logic [7:0]         din;
  logic [7:0]         chg;

  pfm_pkg::pfm_pad_t  pad_q, pad_d;
  logic               cpos_q, cpos_d;
  logic [1:0]         cneg_q, cneg_d;
  logic               hrst_n_q, hrst_n_d;
  logic               wake_q, wake_d;
  logic               ext_q, ext_d;
  logic               irq_q, irq_d;

  logic               aw_have_q, aw_have_d;
  logic               w_have_q, w_have_d;
  logic [7:0]         awaddr_q, awaddr_d;
  logic [7:0]         wbyte_q, wbyte_d;
  logic               wen_q, wen_d;
  logic               awready_q, awready_d;
  logic               wready_q, wready_d;
  logic               bvalid_q, bvalid_d;
  logic [1:0]         bresp_q, bresp_d;
  logic               arready_q, arready_d;
  logic               rvalid_q, rvalid_d;
  logic [1:0]         rresp_q, rresp_d;
  logic [31:0]        rdata_q, rdata_d;

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  // Buffer off reads as zero
  assign din = sync2_q & die_q & pfm_pkg::PIN_MASK;
  assign chg = din ^ din_prev_q;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] src;
    logic [7:0] drv;
    logic       do_wr;
    logic [1:0] st_set;
    logic [1:0] st_clr;
    src        = dout_q;
    drv        = dir_q & pfm_pkg::PIN_MASK;
    do_wr      = 1'b0;
    st_set     = pfm_pkg::RST_ZERO2;
    st_clr     = pfm_pkg::RST_ZERO2;

    dout_d     = dout_q;
    dir_d      = dir_q;
    pull_en_d  = pull_en_q;
    pull_sel_d = pull_sel_q;
    die_d      = die_q;
    wake_en_d  = wake_en_q;
    func_d     = func_q;
    mask_d     = mask_q;

    // Bus write: address and data may arrive in either order
    aw_have_d  = aw_have_q;
    w_have_d   = w_have_q;
    awaddr_d   = awaddr_q;
    wbyte_d    = wbyte_q;
    wen_d      = wen_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wbyte_d  = s_axi_wdata[7:0];
      wen_d    = s_axi_wstrb[0];
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      bvalid_d = 1'b1;
      bresp_d  = addr_ok(awaddr_q) ? pfm_pkg::RESP_OKAY : pfm_pkg::RESP_SLVERR;
      do_wr    = wen_q;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d  = 1'b0;
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;

    if (do_wr) begin
      unique case (awaddr_q)
        pfm_pkg::ADDR_DOUT:     dout_d     = wbyte_q & pfm_pkg::PIN_MASK;
        pfm_pkg::ADDR_DIR:      dir_d      = wbyte_q & pfm_pkg::PIN_MASK;
        pfm_pkg::ADDR_PULL_EN:  pull_en_d  = wbyte_q & pfm_pkg::PIN_MASK;
        pfm_pkg::ADDR_PULL_SEL: pull_sel_d = wbyte_q & pfm_pkg::PIN_MASK;
        pfm_pkg::ADDR_DIN_EN:   die_d      = wbyte_q & pfm_pkg::PIN_MASK;
        pfm_pkg::ADDR_WAKE_EN:  wake_en_d  = wbyte_q & pfm_pkg::PIN_MASK;
        pfm_pkg::ADDR_FUNC:     func_d     = pfm_pkg::pfm_func_t'(wbyte_q);
        pfm_pkg::ADDR_STATUS:   st_clr     = wbyte_q[1:0];
        pfm_pkg::ADDR_MASK:     mask_d     = wbyte_q[1:0];
        default:                do_wr      = 1'b0;
      endcase
    end

    // Bus read
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = addr_ok(s_axi_araddr) ? pfm_pkg::RESP_OKAY : pfm_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        pfm_pkg::ADDR_DOUT:     rdata_d = {24'h00_0000, dout_q};
        pfm_pkg::ADDR_DIR:      rdata_d = {24'h00_0000, dir_q};
        pfm_pkg::ADDR_PULL_EN:  rdata_d = {24'h00_0000, pull_en_q};
        pfm_pkg::ADDR_PULL_SEL: rdata_d = {24'h00_0000, pull_sel_q};
        pfm_pkg::ADDR_DIN_EN:   rdata_d = {24'h00_0000, die_q};
        pfm_pkg::ADDR_WAKE_EN:  rdata_d = {24'h00_0000, wake_en_q};
        pfm_pkg::ADDR_FUNC:     rdata_d = {24'h00_0000, func_q};
        pfm_pkg::ADDR_DIN:      rdata_d = {24'h00_0000, din};
        pfm_pkg::ADDR_STATUS:   rdata_d = {30'h0000_0000, status_q};
        pfm_pkg::ADDR_MASK:     rdata_d = {30'h0000_0000, mask_q};
        default:                rdata_d = 32'h0000_0000;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;

    if (func_q.comp_out_p0) begin
      src[pfm_pkg::PIN0] = comparator_result_out;
    end
    // Timer PWM on pins 4 and 3
    if (func_q.pwm_p4) begin
      src[pfm_pkg::PIN4] = second_timer_pwm_out;
    end
    if (func_q.pwm_p3) begin
      src[pfm_pkg::PIN3] = second_timer_pwm_out;
    end
    // Reset input mode floats pin 5; open drain releases on a one
    if (func_q.rst_en_p5 || (func_q.od_p5 && src[pfm_pkg::PIN5])) begin
      drv[pfm_pkg::PIN5] = 1'b0;
    end
    // Driver follows the selected source, not the latch
    pad_d.out     = src & pfm_pkg::PIN_MASK;
    // Push-pull drive and pulls only while not driving
    pad_d.oe_n    = ~drv;
    pad_d.pull_up = pull_en_q & pull_sel_q & ~drv & pfm_pkg::PIN_MASK;
    pad_d.pull_dn = pull_en_q & ~pull_sel_q & ~drv & pfm_pkg::PIN_MASK;
    pad_d.ibuf_en = die_q & pfm_pkg::PIN_MASK;

    cpos_d   = func_q.comp_pos_p4;
    cneg_d   = func_q.neg_sel;
    hrst_n_d = func_q.rst_en_p5 ? sync2_q[pfm_pkg::PIN5] : 1'b1;

    ext_d = chg[pfm_pkg::PIN0];
    // Only enabled inputs wake the system
    wake_d = sleep_mode && (|(chg & wake_en_q & die_q));

    // Set wins over a same-cycle clear
    st_set[pfm_pkg::ST_EXT]  = ext_d;
    st_set[pfm_pkg::ST_WAKE] = wake_d;
    status_d = (status_q & ~st_clr) | st_set;
    irq_d    = |(status_d & mask_d);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout_q     <= pfm_pkg::RST_ZERO8;
      dir_q      <= pfm_pkg::RST_ZERO8;
      pull_en_q  <= pfm_pkg::RST_ZERO8;
      pull_sel_q <= pfm_pkg::RST_ZERO8;
      die_q      <= pfm_pkg::RST_DIN_EN;
      wake_en_q  <= pfm_pkg::RST_ZERO8;
      func_q     <= pfm_pkg::pfm_func_t'(pfm_pkg::RST_ZERO8);
      status_q   <= pfm_pkg::RST_ZERO2;
      mask_q     <= pfm_pkg::RST_ZERO2;
      sync1_q    <= pfm_pkg::RST_ZERO8;
      sync2_q    <= pfm_pkg::RST_ZERO8;
      din_prev_q <= pfm_pkg::RST_ZERO8;
      pad_q      <= {16'h00ff, 24'h00_0000};
      cpos_q     <= 1'b0;
      cneg_q     <= pfm_pkg::NEG_PIN7;
      hrst_n_q   <= 1'b1;
      wake_q     <= 1'b0;
      ext_q      <= 1'b0;
      irq_q      <= 1'b0;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      awaddr_q   <= pfm_pkg::RST_ZERO8;
      wbyte_q    <= pfm_pkg::RST_ZERO8;
      wen_q      <= 1'b0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= pfm_pkg::RESP_OKAY;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rresp_q    <= pfm_pkg::RESP_OKAY;
      rdata_q    <= 32'h0000_0000;
    end else begin
      dout_q     <= dout_d;
      dir_q      <= dir_d;
      pull_en_q  <= pull_en_d;
      pull_sel_q <= pull_sel_d;
      die_q      <= die_d;
      wake_en_q  <= wake_en_d;
      func_q     <= func_d;
      status_q   <= status_d;
      mask_q     <= mask_d;
      sync1_q    <= pin_in;
      sync2_q    <= sync1_q;
      din_prev_q <= din;
      pad_q      <= pad_d;
      cpos_q     <= cpos_d;
      cneg_q     <= cneg_d;
      hrst_n_q   <= hrst_n_d;
      wake_q     <= wake_d;
      ext_q      <= ext_d;
      irq_q      <= irq_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      awaddr_q   <= awaddr_d;
      wbyte_q    <= wbyte_d;
      wen_q      <= wen_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
    end
  end

  assign s_axi_awready             = awready_q;
  assign s_axi_wready              = wready_q;
  assign s_axi_bvalid              = bvalid_q;
  assign s_axi_bresp               = bresp_q;
  assign s_axi_arready             = arready_q;
  assign s_axi_rvalid              = rvalid_q;
  assign s_axi_rresp               = rresp_q;
  assign s_axi_rdata               = rdata_q;
  assign pad                       = pad_q;
  assign comparator_positive_input = cpos_q;
  assign comparator_negative_input = cneg_q;
  assign hardware_reset_n          = hrst_n_q;
  assign wake_up                   = wake_q;
  assign external_interrupt_line   = ext_q;
  assign irq                       = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pin7_push_pull: assert property (@(posedge aclk) disable iff (!aresetn)
    (dir_q[pfm_pkg::PIN7] && pull_en_q[pfm_pkg::PIN7]) |=>
      (!pad_q.oe_n[pfm_pkg::PIN7] && !pad_q.pull_up[pfm_pkg::PIN7] &&
       pad_q.out[pfm_pkg::PIN7] == $past(dout_q[pfm_pkg::PIN7])))
    else $error("pin 7 output drive or pull wrong");

  a_ibuf_off_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (!die_q[pfm_pkg::PIN6]) |=> (!pad_q.ibuf_en[pfm_pkg::PIN6] && !din_prev_q[pfm_pkg::PIN6]))
    else $error("disabled input buffer still active");

  a_no_wake_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (die_q == pfm_pkg::RST_ZERO8 && $past(die_q) == pfm_pkg::RST_ZERO8) |=> !wake_q)
    else $error("wake with all inputs disabled");

  a_wake_on_chg: assert property (@(posedge aclk) disable iff (!aresetn)
    (sleep_mode && wake_en_q[pfm_pkg::PIN7] && die_q[pfm_pkg::PIN7] && chg[pfm_pkg::PIN7])
      |=> wake_q ##1 status_q[pfm_pkg::ST_WAKE])
    else $error("missed wake-up on pin change");

  a_reset_pin_in: assert property (@(posedge aclk) disable iff (!aresetn)
    func_q.rst_en_p5 |=>
      (pad_q.oe_n[pfm_pkg::PIN5] && hardware_reset_n == $past(sync2_q[pfm_pkg::PIN5])))
    else $error("pin 5 reset mode wrong");

  a_open_drain: assert property (@(posedge aclk) disable iff (!aresetn)
    (func_q.od_p5 && !func_q.rst_en_p5 && dir_q[pfm_pkg::PIN5] && dout_q[pfm_pkg::PIN5])
      |=> pad_q.oe_n[pfm_pkg::PIN5])
    else $error("open drain drives a one");

  a_ext_both_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(din[pfm_pkg::PIN0]) || $fell(din[pfm_pkg::PIN0])) |=>
      (external_interrupt_line && status_q[pfm_pkg::ST_EXT]))
    else $error("pin 0 edge lost");

  a_comp_out_p0: assert property (@(posedge aclk) disable iff (!aresetn)
    func_q.comp_out_p0 |=> pad_q.out[pfm_pkg::PIN0] == $past(comparator_result_out))
    else $error("comparator not on pin 0");

  a_pwm_pin3: assert property (@(posedge aclk) disable iff (!aresetn)
    func_q.pwm_p3 |=> pad_q.out[pfm_pkg::PIN3] == $past(second_timer_pwm_out))
    else $error("pwm not on pin 3");

  a_comp_route: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (comparator_negative_input == $past(func_q.neg_sel) &&
         comparator_positive_input == $past(func_q.comp_pos_p4)))
    else $error("comparator routing wrong");

  a_alt_overrides: assert property (@(posedge aclk) disable iff (!aresetn)
    (func_q.pwm_p4 && dout_q[pfm_pkg::PIN4] != second_timer_pwm_out) |=>
      pad_q.out[pfm_pkg::PIN4] != $past(dout_q[pfm_pkg::PIN4]))
    else $error("latch leaks onto pin 4");

endmodule // pfm_port_mux

`default_nettype wire

/* design/pfm_pkg.sv */
// Package for the six-pin port and pin function mux.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package pfm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DOUT     = 8'h00;
  localparam logic [7:0] ADDR_DIR      = 8'h04;
  localparam logic [7:0] ADDR_PULL_EN  = 8'h08;
  localparam logic [7:0] ADDR_PULL_SEL = 8'h0c;
  localparam logic [7:0] ADDR_DIN_EN   = 8'h10;
  localparam logic [7:0] ADDR_WAKE_EN  = 8'h14;
  localparam logic [7:0] ADDR_FUNC     = 8'h18;
  localparam logic [7:0] ADDR_DIN      = 8'h1c;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_MASK     = 8'h24;

  // ----------------------------------------------------------------
  // Pins and fields
  // ----------------------------------------------------------------
  // Bits 2 and 1 have no pin and read as zero
  localparam logic [7:0] PIN_MASK    = 8'hf9;
  localparam int         PIN0        = 0;
  localparam int         PIN3        = 3;
  localparam int         PIN4        = 4;
  localparam int         PIN5        = 5;
  localparam int         PIN6        = 6;
  localparam int         PIN7        = 7;
  localparam int         ST_EXT      = 0;
  localparam int         ST_WAKE     = 1;

  localparam logic [7:0] RST_DIN_EN  = 8'hf9;
  localparam logic [7:0] RST_ZERO8   = 8'h00;
  localparam logic [1:0] RST_ZERO2   = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Comparator negative input source codes
  localparam logic [1:0] NEG_PIN7    = 2'h0;
  localparam logic [1:0] NEG_PIN6    = 2'h1;
  localparam logic [1:0] NEG_PIN4    = 2'h2;
  localparam logic [1:0] NEG_PIN3    = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       comp_pos_p4;
    logic [1:0] neg_sel;
    logic       pwm_p3;
    logic       pwm_p4;
    logic       comp_out_p0;
    logic       rst_en_p5;
    logic       od_p5;
  } pfm_func_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull_up;
    logic [7:0] pull_dn;
    logic [7:0] ibuf_en;
  } pfm_pad_t;

endpackage

/* testbench/pfm_board.sv */
// Board model for the port pins: external sources, pull resistors, floating lines.
// Assumes pad is registered on aclk; ext_en and ext_val come from the bench.
`timescale 1ns/10ps
`default_nettype none
module pfm_board (
  // Clock and pads
  input  wire logic              aclk,
  input  wire pfm_pkg::pfm_pad_t pad,
  // External sources
  input  wire logic [7:0]        ext_en,
  input  wire logic [7:0]        ext_val,
  // Resolved pin levels
  output logic [7:0]             pin_lvl
);
  logic [7:0] flt_q = 8'h00;

  // A floating pin shows a changing pattern, never a held value
  always @(posedge aclk) flt_q <= ~flt_q;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad.oe_n[i]) pin_lvl[i] = pad.out[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (pad.pull_up[i]) pin_lvl[i] = 1'h1;
      else if (pad.pull_dn[i]) pin_lvl[i] = 1'h0;
      else pin_lvl[i] = flt_q[i];
    end
  end
endmodule // pfm_board
`default_nettype wire

/* testbench/port_pin_function_mux_test.sv */
// Self-checking bench: AXI4-Lite master, board model and reference model of the port.
// Assumes a 10 MHz aclk and synchronous active-low aresetn.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module port_pin_function_mux_test;
  logic              aclk = 1'h0;
  logic              aresetn = 1'h0;
  logic [7:0]        awaddr = 8'h00, araddr = 8'h00, ext_en = 8'hff, ext_val = 8'h00;
  logic [31:0]       wdata = 32'h0000_0000;
  logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic              rready = 1'h0, cmp = 1'h0, pwm = 1'h0, sleep = 1'h0;
  logic              awready, wready, bvalid, arready, rvalid, cpi, rst_n, wake, ext, irq;
  logic [1:0]        bresp, rresp, cni;
  logic [31:0]       rdata;
  logic [7:0]        pin_lvl, src, drv;
  logic [7:0]        m [10];
  pfm_pkg::pfm_pad_t pad;
  int                num_errors = 0, compares = 0, n_ext = 0, n_wk = 0;

  initial forever #50 aclk = ~aclk;

  pfm_port_mux dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin_lvl), .pad(pad), .comparator_result_out(cmp), .second_timer_pwm_out(pwm),
    .comparator_positive_input(cpi), .comparator_negative_input(cni),
    .hardware_reset_n(rst_n), .sleep_mode(sleep), .wake_up(wake),
    .external_interrupt_line(ext), .irq(irq));

  pfm_board board (.aclk(aclk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
    .pin_lvl(pin_lvl));

  always @(posedge aclk) begin
    if (aresetn && ext) n_ext++;
    if (aresetn && wake) n_wk++;
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready) && n < 100);
    if (n >= 100) num_errors++;
    if (a <= 8'h18) m[a[5:2]] = d[7:0] & ((a == 8'h18) ? 8'hff : 8'hf9);
    if (a == 8'h24) m[9] = d[7:0] & 8'h03;
    `CHK("bresp", (a <= 8'h24) ? 2'h0 : 2'h2, bresp)
    bready <= 1'h0;
    @(posedge aclk);
  endtask

  // Only the bits set in k are compared; upper bits must read zero
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] k);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready) && n < 100);
    if (n >= 100) num_errors++;
    `CHK("rdata", {24'h00_0000, e & k}, rdata & {24'hff_ffff, k})
    `CHK("rresp", (a <= 8'h24) ? 2'h0 : 2'h2, rresp)
    rready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Reference pin model
  // ----------------------------------------------------------------
  task automatic chk_pins();
    logic [7:0] lvl;
    logic [7:0] kn;
    src = m[0];
    if (m[6][2]) src[0] = cmp;
    if (m[6][3]) src[4] = pwm;
    if (m[6][4]) src[3] = pwm;
    drv = m[1] & 8'hf9;
    if ((m[6][0] && src[5]) || m[6][1]) drv[5] = 1'h0;
    lvl = (src & drv) | (ext_val & ext_en & ~drv) | (m[2] & m[3] & ~drv & ~ext_en);
    kn = drv | ext_en | m[2];
    `CHK("oe_n", ~drv, pad.oe_n)
    `CHK("out", src & drv, pad.out & drv)
    `CHK("pull_up", m[2] & m[3] & ~drv, pad.pull_up)
    `CHK("pull_dn", m[2] & ~m[3] & ~drv, pad.pull_dn)
    `CHK("ibuf_en", m[4], pad.ibuf_en)
    `CHK("cmp_pos", m[6][7], cpi)
    `CHK("cmp_neg", m[6][6:5], cni)
    rd(8'h1c, lvl & m[4], kn);
  endtask

  initial begin
    logic [31:0] v;
    int          e0;
    int          w0;
    void'($urandom(91675));
    for (int k = 0; k < 10; k++) m[k] = 8'h00;
    m[4] = 8'hf9;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int k = 0; k < 10; k++) rd(8'(k * 4), m[k], 8'hff);
    chk_pins();
    wr(8'h28, 32'h0000_00ff);
    rd(8'h28, 8'h00, 8'hff);
    // Random configurations; reset mode on pin 5 kept off here
    for (int it = 0; it < 24; it++) begin
      for (int k = 0; k < 7; k++) begin
        v = $urandom;
        if (k == 6) v[1] = 1'h0;
        wr(8'(k * 4), v);
      end
      cmp <= 1'($urandom);
      pwm <= 1'($urandom);
      ext_en <= 8'($urandom);
      ext_val <= 8'($urandom);
      repeat (4) @(posedge aclk);
      chk_pins();
      for (int k = 0; k < 7; k++) rd(8'(k * 4), m[k], 8'hff);
    end
    ext_en <= 8'hff;
    ext_val <= 8'h00;
    wr(8'h04, 32'h0000_0000);
    wr(8'h18, 32'h0000_0000);
    wr(8'h10, 32'h0000_00f9);
    wr(8'h20, 32'h0000_0003);
    wr(8'h24, 32'h0000_0001);
    e0 = n_ext;
    ext_val <= 8'h01;
    repeat (6) @(posedge aclk);
    `CHK("ext_cnt", e0 + 1, n_ext)
    `CHK("irq", 1'h1, irq)
    ext_val <= 8'h00;
    repeat (6) @(posedge aclk);
    `CHK("ext_cnt", e0 + 2, n_ext)
    rd(8'h20, 8'h01, 8'hff);
    wr(8'h20, 32'h0000_0001);
    @(posedge aclk);
    `CHK("irq", 1'h0, irq)
    wr(8'h24, 32'h0000_0000);
    ext_val <= 8'h01;
    repeat (6) @(posedge aclk);
    `CHK("irq", 1'h0, irq)
    rd(8'h20, 8'h01, 8'hff);
    wr(8'h14, 32'h0000_00f9);
    sleep <= 1'h1;
    w0 = n_wk;
    // Pins 7 and 3 toggle together: one wake pulse per change
    ext_val <= 8'h89;
    repeat (6) @(posedge aclk);
    ext_val <= 8'h01;
    repeat (6) @(posedge aclk);
    `CHK("wake_cnt", w0 + 2, n_wk)
    wr(8'h10, 32'h0000_0071);
    ext_val <= 8'h89;
    repeat (6) @(posedge aclk);
    `CHK("wake_cnt", w0 + 2, n_wk)
    // All inputs off: dropping pins 7 and 3 must not wake either
    wr(8'h10, 32'h0000_0000);
    ext_val <= 8'h01;
    repeat (6) @(posedge aclk);
    `CHK("wake_cnt", w0 + 2, n_wk)
    rd(8'h20, 8'h02, 8'h02);
    wr(8'h18, 32'h0000_0002);
    ext_val <= 8'h00;
    repeat (6) @(posedge aclk);
    `CHK("hw_rst_n", 1'h0, rst_n)
    `CHK("oe_n5", 1'h1, pad.oe_n[5])
    ext_val <= 8'h20;
    repeat (6) @(posedge aclk);
    `CHK("hw_rst_n", 1'h1, rst_n)
    print_verdict();
  end

  initial begin
    #2_000_000;
    num_errors++;
    print_verdict();
  end
endmodule // port_pin_function_mux_test
`default_nettype wire
